// File: verilog/sag_defs.vh
// Constants for the segment access guard: register map, field layout,
// reset values and region numbering. Definitions only.
`ifndef SAG_DEFS_VH
`define SAG_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SAG_OFF_BORDER 8'h00
`define SAG_OFF_RIGHTS 8'h04
`define SAG_OFF_FLAGS 8'h08
`define SAG_OFF_VADDR 8'h0C
`define SAG_OFF_W 8

// ----------------------------------------
// Border register fields
// ----------------------------------------
`define SAG_B2_HI 12
`define SAG_B2_LO 8
`define SAG_B1_HI 4
`define SAG_B1_LO 0
`define SAG_BORDER_W 5
`define SAG_BORDER_RST 5'h00

// ----------------------------------------
// Access rights register: one nibble per region
// ----------------------------------------
`define SAG_RIGHTS_RST 16'h7777
`define SAG_NIB_W 4
`define SAG_BIT_RE 0
`define SAG_BIT_WE 1
`define SAG_BIT_XE 2
`define SAG_BIT_VS 3

// ----------------------------------------
// Regions, also flag bit positions
// ----------------------------------------
`define SAG_NREG 4
`define SAG_REG_SEG1 2'd0
`define SAG_REG_SEG2 2'd1
`define SAG_REG_SEG3 2'd2
`define SAG_REG_INFO 2'd3
`define SAG_FLAGS_RST 4'h0

// ----------------------------------------
// Bus
// ----------------------------------------
`define SAG_HTRANS_NONSEQ 2'b10
`define SAG_HRESP_OKAY 1'b0
`define SAG_WORD_ZERO 32'h0000_0000
`define SAG_REG_W 16

`endif

// File: verilog/sag_region_check.v
// One region's permission check for a single core access.
// Assumes at most one of fetch, read, write is high at a time.
`timescale 1ns/1ps
`include "sag_defs.vh"

module sag_region_check (
  input wire [`SAG_NIB_W-1:0] rights,
  input wire hit,
  input wire fetch,
  input wire read,
  input wire write,
  output wire viol,
  output wire reset_req
);

  wire re_en;
  wire we_en;
  wire xe_en;
  wire bad_fetch;
  wire bad_write;
  wire bad_read;

  assign re_en = rights[`SAG_BIT_RE];
  assign we_en = rights[`SAG_BIT_WE];
  assign xe_en = rights[`SAG_BIT_XE];

  // ----------------------------------------
  // Violation terms
  // ----------------------------------------
  assign bad_fetch = fetch & ~xe_en;
  assign bad_write = write & ~we_en;
  // Reads only fault when the read, write and execute rights are all off
  assign bad_read = read & ~re_en & ~we_en & ~xe_en;

  assign viol = hit & (bad_fetch | bad_write | bad_read);
  assign reset_req = viol & rights[`SAG_BIT_VS];

endmodule // sag_region_check

// File: verilog/sag_top.v
// Segment access guard: checks core fetches, reads and writes against
// three main memory segments and the user information region.
// Assumes a single AHB-Lite master on clk and a core access port on clk.
//
// Notes on behaviour
// - Second border is a five-bit field at bits 12..8 of border register.
// - First border is a five-bit field at bits 4..0 of border register.
// - Brownout reset clears both borders, leaving segment three alone.
// - Border register bits 15..13 and 7..5 always read as zero.
// - Info violation sets its flag; bit 15 adds a power-up clear.
// - Info execute allow (bit 14, reset 1) low makes fetches violate.
// - Info write allow (bit 13, reset 1) low makes writes violate.
// - Info read violates only if read, write and execute allows low.
// - Segment three violation sets flag; bit 11 adds power-up clear.
// - Segment three execute allow (bit 10) low makes fetches violate.
// - Segment three write allow (bit 9) low makes writes violate.
// - Segment three read violates only if all three allows are low.
// - Segment two violation sets flag; bit 7 adds power-up clear.
// - Segment two execute allow (bit 6) low makes fetches violate.
// - Segment two write allow (bit 5) low makes writes violate.
// - Segment two read violates only if all three allows are low.
// - Segment one violation sets flag; bit 3 adds power-up clear.
// - Segment one execute allow (bit 2) low makes fetches violate.
// - Segment one write allow (bit 1) low makes writes violate.
// - Segment one read violates only if all three allows are low.
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "sag_defs.vh"

module sag_top #(
  parameter ADDR_W = 16,
  parameter GRAN_SHIFT = 11,
  parameter [ADDR_W-1:0] MAIN_BASE = 16'h8000,
  parameter [ADDR_W-1:0] MAIN_END = 16'hFFFF,
  parameter [ADDR_W-1:0] INFO_BASE = 16'h1000,
  parameter [ADDR_W-1:0] INFO_END = 16'h17FF
) (
  input wire clk,
  input wire srst,
  input wire brownout_reset,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Core access port
  input wire acc_valid,
  input wire [ADDR_W-1:0] acc_addr,
  input wire acc_fetch,
  input wire acc_read,
  input wire acc_write,
  // Toward the rest of the unit
  output reg [`SAG_NREG-1:0] violation_flags,
  output reg power_up_clear
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Border value scaled to an absolute address
  function [ADDR_W:0] border_addr;
    input [`SAG_BORDER_W-1:0] b;
    begin
      border_addr = {{(ADDR_W+1-`SAG_BORDER_W){1'b0}}, b} << GRAN_SHIFT;
    end
  endfunction

  // Segment index of a main memory address
  function [1:0] seg_of;
    input [ADDR_W-1:0] a;
    input [`SAG_BORDER_W-1:0] b1;
    input [`SAG_BORDER_W-1:0] b2;
    reg [ADDR_W:0] ax;
    begin
      ax = {1'b0, a};
      if (ax < border_addr(b1)) begin
        seg_of = `SAG_REG_SEG1;
      end else if (ax < border_addr(b2)) begin
        seg_of = `SAG_REG_SEG2;
      end else begin
        seg_of = `SAG_REG_SEG3;
      end
    end
  endfunction

  // Register read mux
  function [31:0] reg_view;
    input [`SAG_OFF_W-1:0] off;
    input [`SAG_BORDER_W-1:0] b1;
    input [`SAG_BORDER_W-1:0] b2;
    input [`SAG_REG_W-1:0] rights;
    input [`SAG_NREG-1:0] flags;
    input [ADDR_W-1:0] va;
    begin
      reg_view = `SAG_WORD_ZERO;
      case (off)
        `SAG_OFF_BORDER: begin
          // Reserved bits stay zero
          reg_view[`SAG_B2_HI:`SAG_B2_LO] = b2;
          reg_view[`SAG_B1_HI:`SAG_B1_LO] = b1;
        end
        `SAG_OFF_RIGHTS: begin
          reg_view[`SAG_REG_W-1:0] = rights;
        end
        `SAG_OFF_FLAGS: begin
          reg_view[`SAG_NREG-1:0] = flags;
        end
        `SAG_OFF_VADDR: begin
          reg_view[ADDR_W-1:0] = va;
        end
        default: begin
          reg_view = `SAG_WORD_ZERO;
        end
      endcase
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [`SAG_BORDER_W-1:0] border_one_q;
  reg [`SAG_BORDER_W-1:0] border_one_d;
  reg [`SAG_BORDER_W-1:0] border_two_q;
  reg [`SAG_BORDER_W-1:0] border_two_d;
  reg [`SAG_REG_W-1:0] rights_q;
  reg [`SAG_REG_W-1:0] rights_d;
  reg [`SAG_NREG-1:0] flags_q;
  reg [`SAG_NREG-1:0] flags_d;
  reg [ADDR_W-1:0] vaddr_q;
  reg [ADDR_W-1:0] vaddr_d;
  reg wr_pend_q;
  reg [`SAG_OFF_W-1:0] wr_off_q;
  reg [31:0] rdata_d;

  // ----------------------------------------
  // Bus address phase
  // ----------------------------------------
  wire addr_take;
  wire [`SAG_OFF_W-1:0] addr_off;
  wire wr_now;

  assign addr_take = hsel & hready & (htrans == `SAG_HTRANS_NONSEQ);
  assign addr_off = haddr[`SAG_OFF_W-1:0];
  assign wr_now = wr_pend_q;

  // ----------------------------------------
  // Region decode
  // ----------------------------------------
  wire in_main;
  wire in_info;
  wire [1:0] seg_idx;
  wire [`SAG_NREG-1:0] hit;
  wire [`SAG_NREG-1:0] viol;
  wire [`SAG_NREG-1:0] rst_req;
  wire any_viol;
  wire any_rst;

  assign in_main = acc_valid & (acc_addr >= MAIN_BASE) &
                   (acc_addr <= MAIN_END);
  assign in_info = acc_valid & (acc_addr >= INFO_BASE) &
                   (acc_addr <= INFO_END);
  assign seg_idx = seg_of(acc_addr, border_one_q, border_two_q);

  genvar r;
  generate
    for (r = 0; r < `SAG_NREG; r = r + 1) begin : g_region
      if (r == `SAG_REG_INFO) begin : g_info
        assign hit[r] = in_info;
      end else begin : g_main
        assign hit[r] = in_main & (seg_idx == r);
      end
      sag_region_check u_check (
        .rights(rights_q[r*`SAG_NIB_W +: `SAG_NIB_W]),
        .hit(hit[r]),
        .fetch(acc_fetch),
        .read(acc_read),
        .write(acc_write),
        .viol(viol[r]),
        .reset_req(rst_req[r])
      );
    end
  endgenerate

  assign any_viol = |viol;
  assign any_rst = |rst_req;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always @* begin
    border_one_d = border_one_q;
    border_two_d = border_two_q;
    rights_d = rights_q;
    flags_d = flags_q;
    vaddr_d = vaddr_q;
    if (wr_now) begin
      case (wr_off_q)
        `SAG_OFF_BORDER: begin
          border_two_d = hwdata[`SAG_B2_HI:`SAG_B2_LO];
          border_one_d = hwdata[`SAG_B1_HI:`SAG_B1_LO];
        end
        `SAG_OFF_RIGHTS: begin
          rights_d = hwdata[`SAG_REG_W-1:0];
        end
        `SAG_OFF_FLAGS: begin
          // Write zero clears, write one leaves alone
          flags_d = flags_q & hwdata[`SAG_NREG-1:0];
        end
        default: begin
          border_one_d = border_one_q;
        end
      endcase
    end
    // Hardware set beats a same-cycle software clear
    flags_d = flags_d | viol;
    if (any_viol) begin
      vaddr_d = acc_addr;
    end
    // Brownout wipes the borders, so segment three covers main
    if (brownout_reset) begin
      border_one_d = `SAG_BORDER_RST;
      border_two_d = `SAG_BORDER_RST;
    end
  end

  // Read data sampled from next-state values so a read right after a
  // write sees the new contents without a wait state.
  always @* begin
    rdata_d = `SAG_WORD_ZERO;
    if (addr_take & ~hwrite) begin
      rdata_d = reg_view(addr_off, border_one_d, border_two_d, rights_d,
                         flags_d, vaddr_d);
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      border_one_q <= `SAG_BORDER_RST;
      border_two_q <= `SAG_BORDER_RST;
      rights_q <= `SAG_RIGHTS_RST;
      flags_q <= `SAG_FLAGS_RST;
      vaddr_q <= {ADDR_W{1'b0}};
      wr_pend_q <= 1'b0;
      wr_off_q <= `SAG_OFF_BORDER;
      hrdata <= `SAG_WORD_ZERO;
      hreadyout <= 1'b1;
      hresp <= `SAG_HRESP_OKAY;
      violation_flags <= `SAG_FLAGS_RST;
      power_up_clear <= 1'b0;
    end else begin
      border_one_q <= border_one_d;
      border_two_q <= border_two_d;
      rights_q <= rights_d;
      flags_q <= flags_d;
      vaddr_q <= vaddr_d;
      wr_pend_q <= addr_take & hwrite;
      if (addr_take) begin
        wr_off_q <= addr_off;
      end
      hrdata <= rdata_d;
      // Zero wait states; unmapped offsets answer OKAY with zero
      hreadyout <= 1'b1;
      hresp <= `SAG_HRESP_OKAY;
      violation_flags <= flags_d;
      // Pulse lands in the cycle the flag shows set
      power_up_clear <= any_rst;
    end
  end

endmodule // sag_top

// File: verif/sag_core_model.sv
// Core model: issues one fetch, write or read per call.
// Assumes clk is the core clock.
`timescale 1ns/1ps
module sag_core_model #(
  parameter ADDR_W = 16
) (
  input wire clk,
  output reg acc_valid,
  output reg [ADDR_W-1:0] acc_addr,
  output reg acc_fetch,
  output reg acc_read,
  output reg acc_write
);
  initial begin
    acc_valid = 1'b0;
    acc_addr = {ADDR_W{1'b0}};
    acc_fetch = 1'b0;
    acc_read = 1'b0;
    acc_write = 1'b0;
  end
  // Kind 0 fetch, 1 write, 2 read; one cycle, entered at an edge
  task access(input [1:0] kind, input [ADDR_W-1:0] a);
    begin
      acc_valid <= 1'b1;
      acc_addr <= a;
      acc_fetch <= kind == 2'd0;
      acc_write <= kind == 2'd1;
      acc_read <= kind == 2'd2;
      @(posedge clk);
      acc_valid <= 1'b0;
      // Idle address must not echo the last one
      acc_addr <= ~a;
      acc_fetch <= 1'b0;
      acc_write <= 1'b0;
      acc_read <= 1'b0;
    end
  endtask
endmodule // sag_core_model

// File: verif/sag_top_sva.sv
// Checker on the sag_top ports.
// Assumes one bus master and one core, both on clk.
`timescale 1ns/1ps
`include "sag_defs.vh"
module sag_chk #(
  parameter ADDR_W = 16,
  parameter [ADDR_W-1:0] MAIN_BASE = 16'h8000,
  parameter [ADDR_W-1:0] INFO_BASE = 16'h1000,
  parameter [ADDR_W-1:0] INFO_END = 16'h17FF
) (
  input wire clk,
  input wire srst,
  input wire brownout_reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire acc_valid,
  input wire [ADDR_W-1:0] acc_addr,
  input wire acc_fetch,
  input wire acc_read,
  input wire acc_write,
  input wire [`SAG_NREG-1:0] violation_flags,
  input wire power_up_clear
);
  reg wr_q;
  reg [15:0] rights_q;
  wire in_info;
  assign in_info = acc_valid && acc_addr >= INFO_BASE && acc_addr <= INFO_END;
  // ----------------------------------------
  // Shadow of the rights register
  // ----------------------------------------
  always @(posedge clk) begin
    wr_q <= !srst && hsel && hready && htrans == 2'b10 && hwrite && haddr[7:0] == 8'h04;
    if (srst) rights_q <= 16'h7777;
    else if (wr_q) rights_q <= hwdata[15:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Select bit taken as it stood at the access, not after a later write
  sequence s_info_viol;
    violation_flags[3] && (power_up_clear == $past(rights_q[15]));
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
  puc_cause_a: assert property (power_up_clear |-> $past(acc_valid))
    else $error("power up clear without access");
  flag_cause_a: assert property (|(violation_flags & ~$past(violation_flags)) |->
    $past(acc_valid)) else $error("flag set without access");
  info_exec_a: assert property (acc_fetch && in_info && !rights_q[14]
    |=> s_info_viol) else $error("info fetch not flagged");
  info_write_a: assert property (acc_write && in_info && !rights_q[13]
    |=> s_info_viol) else $error("info write not flagged");
  info_read_a: assert property (acc_read && in_info && rights_q[14:12] == 3'b000
    |=> s_info_viol) else $error("info read not flagged");
  info_read_ok_a: assert property (acc_read && in_info && rights_q[14:12] != 3'b000
    |=> !power_up_clear) else $error("allowed info read cleared");
  outside_quiet_a: assert property (acc_valid && acc_addr < MAIN_BASE && !in_info
    |=> !power_up_clear) else $error("outside access cleared");
endmodule // sag_chk

bind sag_top sag_chk #(.ADDR_W(ADDR_W), .MAIN_BASE(MAIN_BASE), .INFO_BASE(INFO_BASE),
  .INFO_END(INFO_END)) u_chk (.clk(clk), .srst(srst), .brownout_reset(brownout_reset),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_fetch(acc_fetch), .acc_read(acc_read),
  .acc_write(acc_write), .violation_flags(violation_flags), .power_up_clear(power_up_clear));

// File: verif/tb_segment_access_guard.sv
// Testbench for sag_top: register access over AHB-Lite, core accesses.
// Assumes the checker binds itself and the core model drives the core port.
`timescale 1ns/1ps
`include "sag_defs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_segment_access_guard;
  reg clk, srst, brownout_reset, hsel, hwrite;
  reg [31:0] haddr, hwdata, r;
  reg [1:0] htrans;
  wire [31:0] hrdata;
  wire hreadyout, hresp, hready, acc_valid, acc_fetch, acc_read, acc_write, power_up_clear;
  wire [15:0] acc_addr;
  wire [3:0] violation_flags;
  wire [2:0] hsize = 3'b010;
  integer miscompares = 0, n_compared = 0, g, k;
  reg [15:0] adr [0:3] = '{16'h8FFF, 16'h9000, 16'hC000, 16'h1100};
  reg [3:0] nib [0:3] = '{4'b0011, 4'b1101, 4'b1000, 4'b1110};
  reg [1:0] kind [0:3] = '{2'd0, 2'd1, 2'd2, 2'd2};
  reg vio [0:3] = '{1'b1, 1'b1, 1'b1, 1'b0};
  assign hready = hreadyout;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    srst = 1'b1; brownout_reset = 1'b0; hsel = 1'b0; hwrite = 1'b0;
    haddr = 32'h0000_0000; hwdata = 32'h0000_0000; htrans = 2'b00;
  end
  sag_top u_dut (.clk(clk), .srst(srst), .brownout_reset(brownout_reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_fetch(acc_fetch), .acc_read(acc_read),
    .acc_write(acc_write), .violation_flags(violation_flags), .power_up_clear(power_up_clear));
  sag_core_model u_core (.clk(clk), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .acc_fetch(acc_fetch), .acc_read(acc_read), .acc_write(acc_write));
  task conclude;
    begin
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  // Bounded wait for hready at the next edges
  task wait_rdy;
    integer i;
    begin
      i = 0;
      do begin @(posedge clk); i++; end while (hready !== 1'b1 && i < 16);
      if (hready !== 1'b1) begin miscompares++; conclude; end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'b1; haddr <= {24'h00_0000, a}; htrans <= `SAG_HTRANS_NONSEQ; hwrite <= w;
      wait_rdy;
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      wait_rdy;
      r = hrdata;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      bus(1'b0, a, ~e);
      `CHK("register", e, r)
    end
  endtask
  task acc(input [1:0] kd, input [15:0] a, input [3:0] ef, input ep);
    begin
      u_core.access(kd, a);
      #1;
      `CHK("flags", ef, violation_flags)
      `CHK("clear pulse", ep, power_up_clear)
      @(posedge clk);
      // Pulse must be gone one cycle later
      #1;
      `CHK("clear pulse end", 1'b0, power_up_clear)
      @(posedge clk);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(`SAG_OFF_BORDER, 32'h0000_0000);
    rd(`SAG_OFF_RIGHTS, 32'h0000_7777);
    rd(8'h10, 32'h0000_0000);
    bus(1'b1, `SAG_OFF_FLAGS, 32'hFFFF_FFFF);
    rd(`SAG_OFF_FLAGS, 32'h0000_0000);
    bus(1'b1, `SAG_OFF_BORDER, 32'hFFFF_FFFF);
    rd(`SAG_OFF_BORDER, 32'h0000_1F1F);
    brownout_reset <= 1'b1;
    @(posedge clk);
    brownout_reset <= 1'b0;
    rd(`SAG_OFF_BORDER, 32'h0000_0000);
    // Borders cleared: the bottom of main memory now lies in segment three
    bus(1'b1, `SAG_OFF_RIGHTS, 32'h0000_7577);
    acc(2'd1, 16'h8000, 4'h4, 1'b0);
    bus(1'b1, `SAG_OFF_FLAGS, 32'h0000_0000);
    // Borders 0x12 and 0x14 put the segment edges at 0x9000 and 0xA000
    bus(1'b1, `SAG_OFF_BORDER, 32'h0000_1412);
    bus(1'b1, `SAG_OFF_RIGHTS, 32'h0000_0000);
    acc(2'd0, 16'h4000, 4'h0, 1'b0);
    for (g = 0; g < 4; g++) begin
      for (k = 0; k < 4; k++) begin
        bus(1'b1, `SAG_OFF_RIGHTS, (32'h7777 & ~(32'hF << 4 * g)) | (nib[k] << 4 * g));
        acc(kind[k], adr[g], vio[k] << g, vio[k] & nib[k][3]); // to
        bus(1'b1, `SAG_OFF_FLAGS, 32'h0000_0000);
      end
    end
    // Last violating access in the sweep was the info read
    rd(`SAG_OFF_VADDR, 32'h0000_1100);
    // A software clear landing with a new violation keeps only the new flag
    bus(1'b1, `SAG_OFF_RIGHTS, 32'h0000_7700);
    acc(2'd1, 16'h9000, 4'h2, 1'b0);
    fork
      bus(1'b1, `SAG_OFF_FLAGS, 32'h0000_0000);
      begin
        @(posedge clk);
        u_core.access(2'd1, 16'h8FFF);
      end
    join
    #1;
    `CHK("flags set wins", 4'h1, violation_flags)
    @(posedge clk);
    bus(1'b1, `SAG_OFF_FLAGS, 32'h0000_0000);
    rd(`SAG_OFF_FLAGS, 32'h0000_0000);
    conclude;
  end
endmodule // tb_segment_access_guard
